// ---- hdl/pwm_pkg.sv ----
// package: constants, widths and kinds for the partial-write merge tracker
package pwm_pkg;
  localparam int GPR_W = 64;
  localparam int VEC_W = 128;
  localparam int TAG_W = 6;
  localparam int NREG = 16;
  localparam int RIDX_W = 4;
  localparam logic [3:0] SP_IDX = 4'h4;
  localparam int OFS_W = 16;
  localparam logic [TAG_W-1:0] TAG_NONE = 6'h00;

  // destination write kinds
  typedef enum logic [3:0] {
    PWM_WR_NONE = 4'h0,
    PWM_WR_GPR64 = 4'h1,
    PWM_WR_GPR32 = 4'h2,
    PWM_WR_GPR16 = 4'h3,
    PWM_WR_GPR8 = 4'h4,
    PWM_WR_VEC128 = 4'h5,
    PWM_WR_VEC_HALF = 4'h6,
    PWM_WR_VEC_LO32 = 4'h7,
    PWM_WR_VLD64 = 4'h8,
    PWM_WR_VLD32 = 4'h9,
    PWM_WR_VLO64_OP = 4'hA
  } pwm_wr_type;

  // stack pointer usage classes
  typedef enum logic [2:0] {
    PWM_SP_NONE = 3'h0,
    PWM_SP_PUSHPOP = 3'h1,
    PWM_SP_SRC = 3'h2,
    PWM_SP_MEM_NOIDX = 3'h3,
    PWM_SP_LEA = 3'h4,
    PWM_SP_DEST = 3'h5,
    PWM_SP_MEM_IDX = 3'h6,
    PWM_SP_MICRO = 3'h7
  } pwm_sp_type;

  // sync machine states, gray along idle->sync
  typedef enum logic [1:0] {
    PWM_ST_IDLE = 2'b00,
    PWM_ST_SYNC = 2'b01
  } pwm_state_type;
endpackage

// ---- hdl/pwm_tracker.sv ----
// partial-write merge dependency tracker and stack-pointer offset tracker
//
// Operation
// - partial writes merge new bits with old
// - merging write depends on last writer
// - integer register tracked as one 64-bit unit
// - vector register tracked as one 128-bit unit
// - vector 32-bit write merges remaining bits
// - scalar vector loads zero upper, no merge
// - 32-bit integer writes zero upper, independent
// - sub-32-bit integer writes merge
// - double move: memory zeroes, register merges
// - sqrt, converts, unpacks, half-moves merge low
// - dest-as-source adds no extra delay
// - track stack pointer for parallel push/pop
// - decouple call, ret, leave, sp reads
// - lea, sp writes, indexed, microcoded stay dependent
`timescale 1ns/1ps
module pwm_tracker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // dispatch request
  input wire logic disp_valid,
  output logic disp_ready,
  input wire logic [pwm_pkg::TAG_W-1:0] disp_tag,
  input wire logic disp_is_vec,
  input wire logic [pwm_pkg::RIDX_W-1:0] disp_dst,
  input wire pwm_pkg::pwm_wr_type disp_wr,
  input wire logic disp_dst_is_src,
  input wire pwm_pkg::pwm_sp_type disp_sp,
  input wire logic signed [pwm_pkg::OFS_W-1:0] disp_sp_delta,
  // retirement of a writer clears its tracking
  input wire logic wb_valid,
  input wire logic [pwm_pkg::TAG_W-1:0] wb_tag,
  // dependency answer to execution
  output logic iss_valid,
  output logic [pwm_pkg::TAG_W-1:0] iss_tag,
  output logic iss_merge,
  output logic [pwm_pkg::TAG_W-1:0] iss_merge_tag,
  output logic [pwm_pkg::GPR_W/8-1:0] iss_keep_bytes_gpr,
  output logic [pwm_pkg::VEC_W/8-1:0] iss_keep_bytes_vec,
  output logic iss_sp_decoupled,
  output logic signed [pwm_pkg::OFS_W-1:0] iss_sp_offset,
  // stack pointer synchronisation to register state
  output logic sp_sync_valid,
  output logic signed [pwm_pkg::OFS_W-1:0] sp_sync_offset
);
  // one last-writer tag per whole register; 0 means no pending writer
  logic [pwm_pkg::TAG_W-1:0] gpr_last_r [pwm_pkg::NREG];
  logic [pwm_pkg::TAG_W-1:0] vec_last_r [pwm_pkg::NREG];
  logic signed [pwm_pkg::OFS_W-1:0] sp_ofs_r;
  logic signed [pwm_pkg::OFS_W-1:0] sp_ofs_nxt;
  pwm_pkg::pwm_state_type state_r;
  logic fire;
  logic merge_nxt;
  logic [pwm_pkg::TAG_W-1:0] prev_tag;
  logic [7:0] keep_gpr_nxt;
  logic [15:0] keep_vec_nxt;
  logic sp_decouple;
  logic sp_needs_sync;

  // stall one cycle for sync when an undecoupled sp user arrives with offset pending
  assign sp_decouple = (disp_sp inside {pwm_pkg::PWM_SP_PUSHPOP, pwm_pkg::PWM_SP_SRC,
                        pwm_pkg::PWM_SP_MEM_NOIDX});
  assign sp_needs_sync = (disp_sp inside {pwm_pkg::PWM_SP_LEA, pwm_pkg::PWM_SP_DEST,
                          pwm_pkg::PWM_SP_MEM_IDX, pwm_pkg::PWM_SP_MICRO})
                         && (sp_ofs_r != '0);
  assign disp_ready = !(sp_needs_sync && state_r == pwm_pkg::PWM_ST_IDLE);
  assign fire = disp_valid && disp_ready;
  assign prev_tag = disp_is_vec ? vec_last_r[disp_dst] : gpr_last_r[disp_dst];

  // classify the write: merge or zero-extend, and which bytes keep old contents
  always_comb begin
    merge_nxt = 1'b0;
    keep_gpr_nxt = 8'h00;
    keep_vec_nxt = 16'h0000;
    unique case (disp_wr)
      pwm_pkg::PWM_WR_GPR16: begin
        merge_nxt = 1'b1;
        keep_gpr_nxt = 8'hFC;
      end
      pwm_pkg::PWM_WR_GPR8: begin
        merge_nxt = 1'b1;
        keep_gpr_nxt = 8'hFE;
      end
      pwm_pkg::PWM_WR_VEC_HALF: begin
        merge_nxt = 1'b1;
        keep_vec_nxt = 16'hFF00;
      end
      pwm_pkg::PWM_WR_VEC_LO32: begin
        merge_nxt = 1'b1;
        keep_vec_nxt = 16'hFFF0;
      end
      pwm_pkg::PWM_WR_VLO64_OP: begin
        merge_nxt = 1'b1;
        keep_vec_nxt = 16'hFF00;
      end
      default: begin
        // full, 32-bit integer and scalar loads zero the rest
        merge_nxt = 1'b0;
      end
    endcase
  end

  // last-writer table per whole register, 64 or 128 bits each
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < pwm_pkg::NREG; i++) begin
        gpr_last_r[i] <= pwm_pkg::TAG_NONE;
        vec_last_r[i] <= pwm_pkg::TAG_NONE;
      end
    end else begin
      for (int i = 0; i < pwm_pkg::NREG; i++) begin
        if (wb_valid && gpr_last_r[i] == wb_tag) begin
          gpr_last_r[i] <= pwm_pkg::TAG_NONE;
        end
        if (wb_valid && vec_last_r[i] == wb_tag) begin
          vec_last_r[i] <= pwm_pkg::TAG_NONE;
        end
      end
      // a new writer wins over a same-cycle retirement
      if (fire && disp_wr != pwm_pkg::PWM_WR_NONE) begin
        if (disp_is_vec) begin
          vec_last_r[disp_dst] <= disp_tag;
        end else begin
          gpr_last_r[disp_dst] <= disp_tag;
        end
      end
    end
  end

  // answer to execution: merge source tag and kept-byte masks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iss_valid <= 1'b0;
      iss_tag <= pwm_pkg::TAG_NONE;
      iss_merge <= 1'b0;
      iss_merge_tag <= pwm_pkg::TAG_NONE;
      iss_keep_bytes_gpr <= '0;
      iss_keep_bytes_vec <= '0;
      iss_sp_decoupled <= 1'b0;
      iss_sp_offset <= '0;
    end else begin
      iss_valid <= fire;
      iss_tag <= disp_tag;
      // dest-as-source already waits on this tag, so merging costs nothing more
      iss_merge <= fire && merge_nxt && (prev_tag != pwm_pkg::TAG_NONE);
      iss_merge_tag <= merge_nxt ? prev_tag : pwm_pkg::TAG_NONE;
      iss_keep_bytes_gpr <= disp_is_vec ? 8'h00 : keep_gpr_nxt;
      iss_keep_bytes_vec <= disp_is_vec ? keep_vec_nxt : 16'h0000;
      iss_sp_decoupled <= fire && sp_decouple;
      // an op taken in the sync cycle sees the already synchronised pointer
      iss_sp_offset <= (state_r == pwm_pkg::PWM_ST_SYNC) ? '0 : sp_ofs_r;
    end
  end

  // running stack pointer offset held beside the architectural value
  always_comb begin
    sp_ofs_nxt = sp_ofs_r;
    if (state_r == pwm_pkg::PWM_ST_SYNC) begin
      sp_ofs_nxt = '0;
    end else if (fire && sp_decouple) begin
      sp_ofs_nxt = sp_ofs_r + disp_sp_delta;
    end else if (fire && disp_sp == pwm_pkg::PWM_SP_DEST) begin
      sp_ofs_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ofs_r <= '0;
    end else begin
      sp_ofs_r <= sp_ofs_nxt;
    end
  end

  // sync sequencer: one cycle pushes the pending offset into register state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= pwm_pkg::PWM_ST_IDLE;
      sp_sync_valid <= 1'b0;
      sp_sync_offset <= '0;
    end else begin
      unique case (state_r)
        pwm_pkg::PWM_ST_IDLE: begin
          sp_sync_valid <= 1'b0;
          if (disp_valid && sp_needs_sync) begin
            state_r <= pwm_pkg::PWM_ST_SYNC;
            sp_sync_valid <= 1'b1;
            sp_sync_offset <= sp_ofs_r;
          end
        end
        pwm_pkg::PWM_ST_SYNC: begin
          state_r <= pwm_pkg::PWM_ST_IDLE;
          sp_sync_valid <= 1'b0;
        end
      endcase
    end
  end

  // checks
  chk_merge_tag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    iss_merge |-> iss_valid && iss_merge_tag != pwm_pkg::TAG_NONE)
    else $error("merge without a writer tag");
  chk_zero_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fire && disp_wr inside {pwm_pkg::PWM_WR_VLD64, pwm_pkg::PWM_WR_VLD32,
    pwm_pkg::PWM_WR_GPR32} |=> !iss_merge)
    else $error("zero-extending write merged");
  chk_gpr32_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fire && !disp_is_vec && disp_wr == pwm_pkg::PWM_WR_GPR32 |=> iss_keep_bytes_gpr == 8'h00)
    else $error("32-bit write kept upper bytes");
  chk_narrow_merge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fire && !disp_is_vec && disp_wr == pwm_pkg::PWM_WR_GPR8 |=> iss_keep_bytes_gpr == 8'hFE)
    else $error("byte write lost upper bytes");
  chk_vec_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fire && disp_is_vec && disp_wr == pwm_pkg::PWM_WR_VEC_HALF
    |=> iss_keep_bytes_vec == 16'hFF00)
    else $error("half write did not keep high half");
  chk_vec_lo32: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fire && disp_is_vec && disp_wr == pwm_pkg::PWM_WR_VEC_LO32
    |=> iss_keep_bytes_vec == 16'hFFF0)
    else $error("32-bit vector write did not merge");
  chk_sp_accum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fire && sp_decouple && state_r == pwm_pkg::PWM_ST_IDLE
    |=> sp_ofs_r == $past(sp_ofs_r) + $past(disp_sp_delta))
    else $error("stack offset not accumulated");
  chk_sp_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    disp_valid && sp_needs_sync && state_r == pwm_pkg::PWM_ST_IDLE
    |-> !disp_ready ##1 sp_sync_valid ##1 sp_ofs_r == '0)
    else $error("stack pointer not synchronised");
  chk_no_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    disp_valid && !sp_needs_sync
    |-> disp_ready ##1 (iss_valid && iss_tag == $past(disp_tag)))
    else $error("stall without sync need");
endmodule

// ---- tb/pwm_disp_model.sv ----
// dispatch-stage model: presents one instruction and holds it until taken
`timescale 1ns/1ps
module pwm_disp_model (
  // clock
  input wire logic ref_clk,
  // dispatch request
  output logic disp_valid,
  input wire logic disp_ready,
  output logic [pwm_pkg::TAG_W-1:0] disp_tag,
  output logic disp_is_vec,
  output logic [pwm_pkg::RIDX_W-1:0] disp_dst,
  output pwm_pkg::pwm_wr_type disp_wr,
  output logic disp_dst_is_src,
  output pwm_pkg::pwm_sp_type disp_sp,
  output logic signed [pwm_pkg::OFS_W-1:0] disp_sp_delta,
  // stack pointer sync seen from register state
  input wire logic sp_sync_valid,
  input wire logic signed [pwm_pkg::OFS_W-1:0] sp_sync_offset
);
  int stalls = 0;
  int syncs = 0;
  logic signed [15:0] sync_ofs = 16'h0000;
  // idle request fields at time zero
  initial begin
    disp_valid = 1'b0;
    disp_tag = 6'h00;
    disp_is_vec = 1'b0;
    disp_dst = 4'h0;
    disp_wr = pwm_pkg::PWM_WR_NONE;
    disp_dst_is_src = 1'b0;
    disp_sp = pwm_pkg::PWM_SP_NONE;
    disp_sp_delta = 16'h0000;
  end
  // log every sync pulse seen mid-cycle
  always @(negedge ref_clk) begin
    if (sp_sync_valid === 1'b1) begin
      syncs++;
      sync_ofs = sp_sync_offset;
    end
  end
  // hold the request until ready is seen at an edge, then drop it
  task automatic send(input logic [5:0] t, input logic v, input logic [3:0] d,
    input pwm_pkg::pwm_wr_type w, input pwm_pkg::pwm_sp_type c,
    input logic [15:0] dl, input logic s);
    @(posedge ref_clk);
    disp_valid <= 1'b1;
    disp_tag <= t;
    disp_is_vec <= v;
    disp_dst <= d;
    disp_wr <= w;
    disp_sp <= c;
    disp_sp_delta <= dl;
    disp_dst_is_src <= s;
    stalls = 0;
    @(negedge ref_clk);
    while (disp_ready !== 1'b1) begin
      stalls++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    disp_valid <= 1'b0;
    disp_tag <= ~t;
    @(negedge ref_clk);
  endtask
endmodule

// ---- tb/pwm_tracker_tb.sv ----
// self-checking bench for the partial-write merge tracker
`timescale 1ns/1ps
module pwm_tracker_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_valid = 1'b0;
  logic [5:0] wb_tag = 6'h00;
  logic disp_valid, disp_ready, disp_is_vec, disp_dst_is_src;
  logic [5:0] disp_tag, iss_tag, iss_merge_tag;
  logic [3:0] disp_dst;
  pwm_pkg::pwm_wr_type disp_wr;
  pwm_pkg::pwm_sp_type disp_sp;
  logic signed [15:0] disp_sp_delta, iss_sp_offset, sp_sync_offset;
  logic iss_valid, iss_merge, iss_sp_decoupled, sp_sync_valid;
  logic [7:0] iss_keep_bytes_gpr;
  logic [15:0] iss_keep_bytes_vec;
  int err_count = 0;
  int checks = 0;
  pwm_pkg::pwm_sp_type cl[4] = '{pwm_pkg::PWM_SP_LEA, pwm_pkg::PWM_SP_DEST,
    pwm_pkg::PWM_SP_MEM_IDX, pwm_pkg::PWM_SP_MICRO};
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  pwm_tracker pwm_tracker_i (.ref_clk, .rst_n, .disp_valid, .disp_ready, .disp_tag,
    .disp_is_vec, .disp_dst, .disp_wr, .disp_dst_is_src, .disp_sp, .disp_sp_delta,
    .wb_valid, .wb_tag, .iss_valid, .iss_tag, .iss_merge, .iss_merge_tag,
    .iss_keep_bytes_gpr, .iss_keep_bytes_vec, .iss_sp_decoupled, .iss_sp_offset,
    .sp_sync_valid, .sp_sync_offset);
  pwm_disp_model pwm_disp_model_i (.ref_clk, .disp_valid, .disp_ready, .disp_tag,
    .disp_is_vec, .disp_dst, .disp_wr, .disp_dst_is_src, .disp_sp, .disp_sp_delta,
    .sp_sync_valid, .sp_sync_offset);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one dispatch, answer pulse and tag checked
  task automatic go(input logic [5:0] t, input logic v, input logic [3:0] d,
    input pwm_pkg::pwm_wr_type w, input pwm_pkg::pwm_sp_type c = pwm_pkg::PWM_SP_NONE,
    input logic [15:0] dl = 16'h0000, input logic s = 1'b0);
    pwm_disp_model_i.send(t, v, d, w, c, dl, s);
    cmp(16'(iss_valid), 16'h0001);
    cmp(16'(iss_tag), 16'(t));
  endtask
  // merge flag, last writer and kept bytes
  task automatic wm(input logic m, input logic [5:0] mt, input logic [15:0] k);
    cmp(16'(iss_merge), 16'(m));
    cmp(16'(iss_merge_tag), 16'(mt));
    cmp(disp_is_vec ? iss_keep_bytes_vec : {8'h00, iss_keep_bytes_gpr}, k);
  endtask
  task automatic retire(input logic [5:0] t);
    @(posedge ref_clk);
    wb_valid <= 1'b1;
    wb_tag <= t;
    @(posedge ref_clk);
    wb_valid <= 1'b0;
    wb_tag <= 6'h3F;
  endtask
  // integer register widths on one destination
  task automatic s_int;
    go(6'h03, 0, 4'h1, pwm_pkg::PWM_WR_GPR64); wm(0, 6'h00, 16'h0000);
    go(6'h05, 0, 4'h1, pwm_pkg::PWM_WR_GPR8); wm(1, 6'h03, 16'h00FE);
    go(6'h06, 0, 4'h1, pwm_pkg::PWM_WR_GPR16); wm(1, 6'h05, 16'h00FC);
    go(6'h07, 0, 4'h1, pwm_pkg::PWM_WR_GPR32); wm(0, 6'h00, 16'h0000);
    go(6'h08, 0, 4'h1, pwm_pkg::PWM_WR_GPR8); wm(1, 6'h07, 16'h00FE);
    retire(6'h08);
    go(6'h09, 0, 4'h1, pwm_pkg::PWM_WR_GPR8); wm(0, 6'h00, 16'h00FE);
  endtask
  // vector register partial writes and scalar loads
  task automatic s_vec;
    go(6'h0A, 1, 4'h2, pwm_pkg::PWM_WR_VEC128); wm(0, 6'h00, 16'h0000);
    go(6'h0B, 1, 4'h2, pwm_pkg::PWM_WR_VEC_HALF); wm(1, 6'h0A, 16'hFF00);
    go(6'h0C, 1, 4'h2, pwm_pkg::PWM_WR_VEC_LO32); wm(1, 6'h0B, 16'hFFF0);
    go(6'h0D, 1, 4'h2, pwm_pkg::PWM_WR_VLO64_OP, pwm_pkg::PWM_SP_NONE, 16'h0000, 1'b1);
    wm(1, 6'h0C, 16'hFF00);
    go(6'h0E, 1, 4'h2, pwm_pkg::PWM_WR_VLD64); wm(0, 6'h00, 16'h0000);
    go(6'h0F, 1, 4'h2, pwm_pkg::PWM_WR_VLD32); wm(0, 6'h00, 16'h0000);
  endtask
  // stack pointer tracking, then every undecoupled class
  task automatic s_stack;
    int s0;
    logic [15:0] e;
    s0 = pwm_disp_model_i.syncs;
    go(6'h14, 0, 4'h4, pwm_pkg::PWM_WR_NONE, pwm_pkg::PWM_SP_PUSHPOP, 16'hFFF8);
    cmp(16'(iss_sp_decoupled), 16'h0001);
    go(6'h15, 0, 4'h4, pwm_pkg::PWM_WR_NONE, pwm_pkg::PWM_SP_PUSHPOP, 16'hFFF8);
    cmp(iss_sp_offset, 16'hFFF8);
    go(6'h16, 0, 4'h4, pwm_pkg::PWM_WR_NONE, pwm_pkg::PWM_SP_MEM_NOIDX);
    cmp(iss_sp_offset, 16'hFFF0);
    go(6'h17, 0, 4'h4, pwm_pkg::PWM_WR_NONE, pwm_pkg::PWM_SP_SRC);
    cmp(16'(pwm_disp_model_i.syncs - s0), 16'h0000);
    e = 16'hFFF0;
    for (int i = 0; i < 4; i++) begin
      s0 = pwm_disp_model_i.syncs;
      go(6'(8'h18 + 2 * i), 0, 4'h4, pwm_pkg::PWM_WR_NONE, cl[i]);
      cmp(16'(pwm_disp_model_i.stalls), 16'h0001);
      cmp(16'(pwm_disp_model_i.syncs - s0), 16'h0001);
      cmp(pwm_disp_model_i.sync_ofs, e);
      cmp({15'h0000, iss_sp_decoupled} | iss_sp_offset, 16'h0000);
      go(6'(8'h19 + 2 * i), 0, 4'h4, pwm_pkg::PWM_WR_NONE,
        pwm_pkg::PWM_SP_PUSHPOP, 16'hFFF8);
      e = 16'hFFF8;
    end
  endtask
  task test_done;
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    err_count++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_int;
    s_vec;
    s_stack;
    test_done;
  end
endmodule
